// ---- hdl/mmx_pkg.sv ----
// Package for the move and multiply instruction executor
package mmx_pkg;
  // Register layout
  localparam int          AXI_AW          = 8;
  localparam logic [7:0]  ADDR_BANK       = 8'h00;
  localparam logic [7:0]  ADDR_ACC        = 8'h04;
  localparam logic [7:0]  ADDR_PROD       = 8'h08;
  localparam logic [7:0]  ADDR_STATUS     = 8'h0C;
  localparam logic [7:0]  ADDR_INSTR      = 8'h10;
  localparam logic [7:0]  ADDR_FILE_BASE  = 8'h80;
  localparam logic [7:0]  ACC_FILE_ADDR   = 8'h0A;
  localparam logic [7:0]  PERIPH_MAX      = 8'h1F;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  localparam logic [15:0] NOP_WORD        = 16'h0000;
  // Opcode patterns
  localparam logic [2:0]  OP_F2P          = 3'h3;
  localparam logic [2:0]  OP_P2F          = 3'h2;
  localparam logic [7:0]  OP_STORE_ACC    = 8'h01;
  localparam logic [7:0]  OP_LOAD_LIT     = 8'hB0;
  localparam logic [7:0]  OP_BANK_LO      = 8'hB8;
  localparam logic [6:0]  OP_BANK_HI      = 7'h5D;
  localparam logic [7:0]  OP_MUL_LIT      = 8'hBC;
  // Data file depth
  localparam int          FILE_DEPTH      = 16;

  typedef enum logic [1:0] {MMX_Q1, MMX_Q2, MMX_Q3, MMX_Q4} mmx_phase_t;
  typedef enum logic [2:0] {
    MMX_NONE, MMX_F2P, MMX_P2F, MMX_STORE, MMX_LIT, MMX_BLO, MMX_BHI, MMX_MUL
  } mmx_op_t;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] bank;
    logic [7:0] prod_hi;
    logic [7:0] prod_lo;
    logic       zero;
  } mmx_core_t;
endpackage : mmx_pkg

// ---- hdl/mmx_exec.sv ----
// Move and multiply instruction executor with AXI4-Lite access
`timescale 1ns/1ps
module mmx_exec
  import mmx_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [1:0]       phase
);

  // Register map targets, shared by the write and read paths
  typedef enum logic [2:0] {
    MMX_MAP_NONE,
    MMX_MAP_BANK,
    MMX_MAP_ACC,
    MMX_MAP_PROD,
    MMX_MAP_STATUS,
    MMX_MAP_INSTR,
    MMX_MAP_FILE
  } mmx_map_t;

  // Whole state of the block in one packed struct
  typedef struct packed {
    mmx_core_t                    core;
    mmx_phase_t                   ph;
    logic [15:0]                  instr;
    logic                         pend;
    logic [7:0]                   rd_data;
    logic [FILE_DEPTH-1:0][7:0]   file;
    logic                         aw_got;
    logic                         w_got;
    logic [7:0]                   aw_addr;
    logic [31:0]                  w_data;
    logic [3:0]                   w_strb;
    logic                         bvalid;
    logic [1:0]                   bresp;
    logic                         rvalid;
    logic [31:0]                  rdata;
    logic [1:0]                   rresp;
  } mmx_state_t;

  mmx_state_t st_ff;
  mmx_state_t nxt_st;

  // Instruction class decode, shared by phases
  function automatic mmx_op_t decode(input logic [15:0] w);
    if (w[15:13] == OP_F2P) begin
      return MMX_F2P;
    end else if (w[15:13] == OP_P2F) begin
      return MMX_P2F;
    end else if (w[15:8] == OP_STORE_ACC) begin
      return MMX_STORE;
    end else if (w[15:8] == OP_LOAD_LIT) begin
      return MMX_LIT;
    end else if (w[15:8] == OP_BANK_LO) begin
      return MMX_BLO;
    end else if (w[15:9] == OP_BANK_HI) begin
      return MMX_BHI;
    end else if (w[15:8] == OP_MUL_LIT) begin
      return MMX_MUL;
    end
    return MMX_NONE;
  endfunction : decode

  // Data-space read; accumulator address reads the accumulator
  function automatic logic [7:0] file_rd(input mmx_state_t s, input logic [7:0] a);
    if (a == ACC_FILE_ADDR) begin
      return s.core.acc;
    end
    return s.file[a[3:0]];
  endfunction : file_rd

  // Bus address decode; the data file sits in a window of word slots
  function automatic mmx_map_t map_decode(input logic [7:0] a);
    logic [7:0] off;
    off = a - ADDR_FILE_BASE;
    if (a == ADDR_BANK) begin
      return MMX_MAP_BANK;
    end else if (a == ADDR_ACC) begin
      return MMX_MAP_ACC;
    end else if (a == ADDR_PROD) begin
      return MMX_MAP_PROD;
    end else if (a == ADDR_STATUS) begin
      return MMX_MAP_STATUS;
    end else if (a == ADDR_INSTR) begin
      return MMX_MAP_INSTR;
    end else if (a >= ADDR_FILE_BASE && off[7:2] < 6'(FILE_DEPTH)) begin
      return MMX_MAP_FILE;
    end
    return MMX_MAP_NONE;
  endfunction : map_decode

  // Word slot of a file address inside the window
  function automatic logic [3:0] file_slot(input logic [7:0] a);
    logic [7:0] off;
    off = a - ADDR_FILE_BASE;
    return off[5:2];
  endfunction : file_slot

  mmx_op_t     op;
  logic [7:0]  src_a;
  logic [7:0]  dst_a;
  logic [7:0]  wr_val;
  logic        dst_acc;
  logic [7:0]  lit8;
  logic [3:0]  lit_lo;
  logic [3:0]  lit_hi;
  logic [15:0] product;

  // Operand fields of the held word
  always_comb begin
    op     = decode(st_ff.instr);
    lit8   = st_ff.instr[7:0];
    lit_lo = st_ff.instr[3:0];  // Bits 7:4 of the word ignored
    lit_hi = st_ff.instr[7:4];  // Bits 3:0 and 8 of the word ignored
  end

  // Source and destination data addresses by instruction class
  always_comb begin
    src_a = st_ff.instr[7:0];
    dst_a = {3'h0, st_ff.instr[12:8]};
    unique case (op)
      MMX_P2F: begin
        src_a = {3'h0, st_ff.instr[12:8]};  // Short peripheral address
        dst_a = st_ff.instr[7:0];
      end
      MMX_STORE: begin
        dst_a = st_ff.instr[7:0];  // Any of the full data space
      end
      default: begin
        dst_a = {3'h0, st_ff.instr[12:8]};  // Short peripheral address
      end
    endcase
  end

  // Value and target of the Q4 data write
  always_comb begin
    dst_acc = (dst_a == ACC_FILE_ADDR);
    wr_val  = (op == MMX_STORE) ? st_ff.core.acc : st_ff.rd_data;
  end

  // Unsigned 8x8 product; no carry or overflow can arise
  always_comb begin
    product = st_ff.core.acc * lit8;
  end

  // Next state: bus slave and four-phase execution
  always_comb begin
    nxt_st = st_ff;
    // Write address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_got  = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_got  = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end
    // Answer dropped once the master has taken it
    if (s_axi_bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    // Commit a write once both halves are held
    if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = RESP_OKAY;
      // Target chosen by the shared address decode
      unique case (map_decode(st_ff.aw_addr))
        MMX_MAP_INSTR: begin
          // A second word while one is in flight is refused and dropped
          if (st_ff.pend) begin
            nxt_st.bresp = RESP_SLVERR;
          end else begin
            nxt_st.pend  = 1'b1;
            nxt_st.instr = st_ff.w_data[15:0];
          end
        end
        MMX_MAP_BANK: begin
          if (st_ff.w_strb[0]) begin
            nxt_st.core.bank = st_ff.w_data[7:0];
          end
        end
        MMX_MAP_ACC: begin
          if (st_ff.w_strb[0]) begin
            nxt_st.core.acc = st_ff.w_data[7:0];
          end
        end
        MMX_MAP_FILE: begin
          if (st_ff.w_strb[0]) begin
            nxt_st.file[file_slot(st_ff.aw_addr)] = st_ff.w_data[7:0];
          end
        end
        // Product and status are read-only; holes are refused
        MMX_MAP_PROD, MMX_MAP_STATUS, MMX_MAP_NONE: nxt_st.bresp = RESP_SLVERR;
      endcase
    end
    // Read channel
    if (s_axi_rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    // Address taken: the answer stands from the next edge
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = RESP_OKAY;
      nxt_st.rdata  = 32'h0000_0000;
      // Unused upper data bits read as zero
      unique case (map_decode(s_axi_araddr))
        MMX_MAP_BANK:   nxt_st.rdata[7:0] = st_ff.core.bank;
        MMX_MAP_ACC:    nxt_st.rdata[7:0] = st_ff.core.acc;
        MMX_MAP_PROD:   nxt_st.rdata[15:0] = {st_ff.core.prod_hi, st_ff.core.prod_lo};
        MMX_MAP_STATUS: nxt_st.rdata[1:0] = {st_ff.pend, st_ff.core.zero};
        MMX_MAP_INSTR:  nxt_st.rdata[15:0] = st_ff.instr;
        MMX_MAP_FILE:   nxt_st.rdata[7:0] = st_ff.file[file_slot(s_axi_araddr)];
        // Holes in the map answer with an error and zero data
        MMX_MAP_NONE:   nxt_st.rresp = RESP_SLVERR;
      endcase
    end
    // Four-phase instruction cycle, runs only with a pending word
    if (st_ff.pend) begin
      unique case (st_ff.ph)
        MMX_Q1: nxt_st.ph = MMX_Q2;
        // Q2 fetches the source operand
        MMX_Q2: begin
          nxt_st.ph      = MMX_Q3;
          nxt_st.rd_data = file_rd(st_ff, src_a);
        end
        MMX_Q3: nxt_st.ph = MMX_Q4;
        // Q4 writes the result and retires the word
        MMX_Q4: begin
          nxt_st.ph   = MMX_Q1;
          nxt_st.pend = 1'b0;
          unique case (op)
            MMX_F2P, MMX_P2F, MMX_STORE: begin
              // Destination write in Q4
              if (dst_acc) begin
                nxt_st.core.acc = wr_val;
              end else begin
                nxt_st.file[dst_a[3:0]] = wr_val;
              end
              if (op == MMX_P2F) begin
                nxt_st.core.zero = (st_ff.rd_data == 8'h00);
              end
            end
            MMX_LIT: nxt_st.core.acc = lit8;
            MMX_BLO: nxt_st.core.bank[3:0] = lit_lo;
            MMX_BHI: nxt_st.core.bank[7:4] = lit_hi;
            MMX_MUL: begin
              nxt_st.core.prod_hi = product[15:8];
              nxt_st.core.prod_lo = product[7:0];
            end
            MMX_NONE: begin
              // Undecoded words retire; same-cycle bus writes still land
              nxt_st.pend = 1'b0;
            end
          endcase
        end
      endcase
    end
  end

  // State register, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff       <= '0;
      st_ff.instr <= NOP_WORD;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Bus handshakes and outputs
  assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
  assign s_axi_wready  = !st_ff.w_got && !st_ff.bvalid;

  // Answers come straight from the registered state
  assign s_axi_bvalid  = st_ff.bvalid;
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_rvalid  = st_ff.rvalid;
  assign s_axi_rdata   = st_ff.rdata;
  assign s_axi_rresp   = st_ff.rresp;
  assign phase         = st_ff.ph;

endmodule : mmx_exec

// ---- bench/mmx_exec_assertions.sv ----
// Checker for the executor's bus and phase ports
`timescale 1ns/1ps
module mmx_exec_assertions
  import mmx_pkg::*;
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [1:0] phase
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Bus handshakes and phase sequence
  a_phase_step: assert property (phase == 2'h1 |=> phase == 2'h2)
    else $error("phase did not advance");
  a_phase_wrap: assert property (phase == 2'h3 |=> phase == 2'h0)
    else $error("phase did not wrap");
  a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while answering");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  a_unmapped_err: assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr == 8'h14
    && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  cover property (phase == 2'h3);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule : mmx_exec_assertions
bind mmx_exec mmx_exec_assertions u_chk (.*);

// ---- bench/mmx_prog_mem.sv ----
// Program memory model holding the test instruction words
`timescale 1ns/1ps
module mmx_prog_mem
  import mmx_pkg::*;
(
  input  wire logic [3:0] pc,
  output logic      [15:0] word
);
  // Test program, one word per step
  always_comb begin
    case (pc)
      4'h0: word = 16'hB05A;
      4'h1: word = 16'hB8F5;
      4'h2: word = 16'hBB5E;
      4'h3: word = 16'hB0E2;
      4'h4: word = 16'hBCC4;
      4'h5: word = 16'h0103;
      4'h6: word = 16'h6203;
      4'h7: word = 16'h4506;
      4'h8: word = 16'h4A07;
      4'h9: word = 16'hBC00;
      default: word = NOP_WORD;
    endcase
  end
endmodule : mmx_prog_mem

// ---- bench/test_move_and_multiply_instr_exec.sv ----
// Testbench for the move and multiply executor
`timescale 1ns/1ps
module test_move_and_multiply_instr_exec;
  import mmx_pkg::*;
  logic aclk = 0, aresetn = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF, pc = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, phase, r;
  logic [15:0] word;
  int failures = 0, cmp_count = 0, cycles = 0;
  logic [7:0] ea [9] = '{ADDR_ACC, ADDR_BANK, ADDR_BANK, ADDR_ACC, ADDR_PROD, 8'h8C, 8'h88,
                        ADDR_STATUS, 8'h9C};
  logic [31:0] ev [9] = '{32'h5A, 32'h25, 32'h55, 32'hE2, 32'hAD08, 32'hE2, 32'hE2, 32'h1, 32'hE2};
  mmx_exec dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .phase);
  mmx_prog_mem prog (.pc, .word);
  always #25 aclk = ~aclk;
  // Hang guard
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      finish_test();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  // Write with address and data offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ta, tw, aw, w;
    aw = 0;
    w = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      aw = aw | ta;
      w = w | tw;
    end while (!(aw && w));
    do begin
      @(negedge aclk);
      ta = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
    end while (!ta);
    s_axi_bready <= 0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic t;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(negedge aclk);
      t = s_axi_arready;
      @(posedge aclk);
    end while (!t);
    s_axi_arvalid <= 0;
    do begin
      @(negedge aclk);
      t = s_axi_rvalid;
      v = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
    end while (!t);
    s_axi_rready <= 0;
  endtask : axi_rd
  // Run one program word and wait until it retires
  task automatic exec(input logic [3:0] k);
    logic [31:0] v;
    logic [1:0] rs;
    pc <= k;
    @(posedge aclk);
    axi_wr(ADDR_INSTR, {16'h0000, word}, rs);
    check(32'(rs), 32'(RESP_OKAY));
    do axi_rd(ADDR_STATUS, v, rs); while (v[1] !== 1'b0);
  endtask : exec
  task automatic finish_test();
    if (failures == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  // Main sequence
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    axi_rd(ADDR_BANK, d, r);
    check(d, 32'h0);
    axi_wr(ADDR_BANK, 32'h22, r);
    axi_wr(8'h98, 32'h77, r);
    for (int i = 0; i < 9; i++) begin
      exec(4'(i));
      axi_rd(ea[i], d, r);
      check(d, ev[i]);
    end
    exec(4'h9);
    axi_rd(ADDR_PROD, d, r);
    check(d, 32'h0);
    axi_rd(8'h98, d, r);
    check(d, 32'h0);
    axi_rd(ADDR_STATUS, d, r);
    check(d, 32'h0);
    axi_rd(ADDR_ACC, d, r);
    check(d, 32'hE2);
    axi_rd(8'h14, d, r);
    check(32'(r), 32'(RESP_SLVERR));
    axi_wr(8'h14, 32'h1, r);
    check(32'(r), 32'(RESP_SLVERR));
    finish_test();
  end
endmodule : test_move_and_multiply_instr_exec
